// >>> logic/ccrs_regset.sv
// Programmer-visible register set of the 8-bit core with its stack sequencer
// Overview of operation
// - Six core registers, reached only through commands, never through memory addresses.
// - Eight-bit accumulator supplies operands and takes ALU results.
// - Two eight-bit index registers; the prefix selects the second one.
// - Interrupt save and restore never touch the second index register.
// - Sixteen-bit program counter built from separate low and high bytes.
// - Flag byte pushed and popped; every bit set or cleared singly.
// - Half carry reflects carry from bit 3 into 4 on add and add-with-carry.
// - Negative flag copies result bit 7 after data operations.
// - Zero flag set when result is zero, cleared otherwise.
// - Carry from arithmetic, bit test, shifts; set and clear carry commands.
// - Priority bits five and three encode levels 0 to 3, 3 disables.
// - Interrupt entry loads priority bits from the source priority setting.
// - Enable, disable, return, halt, wait and flag pop also set priority.
// - Stack pointer names next free byte; decrement after push, increment before pop.
// - Stack 128 bytes, upper bits fixed; reset and reinit give 017f.
// - Stack pointer low byte loadable like an ordinary operand.
// - Stack pointer wraps silently at both limits.
// - Interrupt entry stores program counter low byte first at the pointer.
// - Call uses two stack bytes, interrupt five.
module ccrs_regset
	import ccrs_pkg::*;
(
	input  wire logic          clk,       // CPU clock
	input  wire logic          rstn,      // Async reset, active low
	input  wire logic          ce,        // Clock enable, freezes all state
	input  wire logic          cmdValid,  // Command offered
	input  ccrs_cmd_type       cmd,       // Command and operands
	output logic               cmdReady,  // Command can be taken
	output ccrs_view_type      regs,      // Register contents
	output ccrs_stk_type       stkPort,   // Stack memory request
	input  wire logic [7:0]    stkRData   // Stack read data, one cycle latency
);

	typedef enum logic [2:0] {S_IDLE, S_PUSH, S_POP_REQ, S_POP_WAIT, S_POP_DATA} ccrs_state_type;

	ccrs_state_type state_ff;
	ccrs_seq_type   seq_ff;
	ccrs_slot_type  curSlot;
	logic [2:0]     step_ff;
	logic [15:0]    target_ff;
	logic [1:0]     prio_ff;
	logic [6:0]     startLow_ff;
	logic [7:0]     acc_ff;
	logic [7:0]     idxX_ff;
	logic [7:0]     idxY_ff;
	logic [15:0]    pc_ff;
	logic [7:0]     cc_ff;
	ccrs_stk_type   stk_ff;
	logic [7:0]     slotValue;
	logic [7:0]     aluResult;
	logic [7:0]     aluCc;
	logic           aluWrites;
	logic [15:0]    spOut;
	logic [15:0]    spInc;
	logic           cmdTake;
	logic           pushLast;
	logic           popLast;
	logic           pushing;
	logic           popping;

	// ************************************************************
	// Submodules
	// ************************************************************
	ccrs_flag_unit flagUnit (
		.alu          (cmd.alu),
		.opA          (cmd.data),
		.opB          (cmd.opB),
		.carryIn      (cmd.carryIn),
		.ccIn         (cc_ff),
		.result       (aluResult),
		.ccOut        (aluCc),
		.writesResult (aluWrites)
	);

	ccrs_stack_ptr stackPtr (
		.clk     (clk),
		.rstn    (rstn),
		.ce      (ce),
		.reinit  (cmdTake && cmd.op == OP_RSP),
		.loadLow (cmdTake && cmd.op == OP_LD_SPL),
		.lowIn   (cmd.data),
		.dec     (pushing),
		.inc     (popping),
		.spOut   (spOut),
		.spInc   (spInc)
	);

	// ************************************************************
	// Handshake and sequence decode
	// ************************************************************
	assign cmdReady = (state_ff == S_IDLE);
	assign cmdTake  = cmdValid && cmdReady && ce;
	assign curSlot  = seqSlot(seq_ff, step_ff);
	assign pushLast = (state_ff == S_PUSH) && (step_ff == seqLen(seq_ff) - 3'h1);
	assign popLast  = (state_ff == S_POP_DATA) && (step_ff == 3'h0);
	assign pushing  = ce && (state_ff == S_PUSH);
	assign popping  = ce && (state_ff == S_POP_REQ);

	// Byte stored for the current push slot; second index never listed
	always_comb begin
		unique case (curSlot)
			SLOT_PCL: slotValue = pc_ff[7:0];
			SLOT_PCH: slotValue = pc_ff[15:8];
			SLOT_X:   slotValue = idxX_ff;
			SLOT_A:   slotValue = acc_ff;
			SLOT_CC:  slotValue = cc_ff;
			default:  slotValue = 8'h00;
		endcase
	end

	// ************************************************************
	// Sequencer
	// ************************************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= S_IDLE;
			seq_ff <= SEQ_CC;
			step_ff <= 3'h0;
			target_ff <= 16'h0000;
			prio_ff <= PRIO_LVL3;
			startLow_ff <= SP_RESET[6:0];
		end else if (ce) begin
			unique case (state_ff)
				S_IDLE: begin
					if (cmdTake) begin
						startLow_ff <= spOut[6:0];
						target_ff <= cmd.addr;
						prio_ff <= cmd.prio;
						unique case (cmd.op)
							OP_INT_ENTER, OP_CALL, OP_PUSH_CC: begin
								state_ff <= S_PUSH;
								step_ff <= 3'h0;
								seq_ff <= (cmd.op == OP_INT_ENTER) ? SEQ_INT :
									((cmd.op == OP_CALL) ? SEQ_CALL : SEQ_CC);
							end
							OP_INTERRUPT_RETURN_INSTR, OP_RET, OP_POP_CC: begin
								state_ff <= S_POP_REQ;
								seq_ff <= (cmd.op == OP_INTERRUPT_RETURN_INSTR) ? SEQ_INT :
									((cmd.op == OP_RET) ? SEQ_CALL : SEQ_CC);
								step_ff <= (cmd.op == OP_INTERRUPT_RETURN_INSTR) ? LEN_INT - 3'h1 :
									((cmd.op == OP_RET) ? LEN_CALL - 3'h1 : 3'h0);
							end
							default: state_ff <= S_IDLE;
						endcase
					end
				end
				S_PUSH: begin
					if (pushLast)
						state_ff <= S_IDLE;
					else
						step_ff <= step_ff + 3'h1;
				end
				S_POP_REQ: state_ff <= S_POP_WAIT;
				S_POP_WAIT: state_ff <= S_POP_DATA;
				S_POP_DATA: begin
					if (popLast) begin
						state_ff <= S_IDLE;
					end else begin
						step_ff <= step_ff - 3'h1;
						state_ff <= S_POP_REQ;
					end
				end
			endcase
		end
	end

	// Stack request, registered; pushes go at the pointer, pops one above
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stk_ff <= '0;
		end else if (ce) begin
			stk_ff <= '0;
			if (state_ff == S_PUSH)
				stk_ff <= '{addr: spOut, wdata: slotValue, we: 1'b1, re: 1'b0};
			else if (state_ff == S_POP_REQ)
				stk_ff <= '{addr: spInc, wdata: 8'h00, we: 1'b0, re: 1'b1};
		end
	end

	// ************************************************************
	// Core registers
	// ************************************************************
	// Accumulator
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			acc_ff <= 8'h00;
		end else if (ce) begin
			if (cmdTake && cmd.op == OP_WR_ACC)
				acc_ff <= cmd.data;
			else if (cmdTake && cmd.op == OP_ALU && aluWrites)
				acc_ff <= aluResult;
			else if (state_ff == S_POP_DATA && curSlot == SLOT_A)
				acc_ff <= stkRData;
		end
	end

	// Index registers; only the first one is part of the saved context
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			idxX_ff <= 8'h00;
			idxY_ff <= 8'h00;
		end else if (ce) begin
			if (cmdTake && cmd.op == OP_WR_IDX && cmd.usePrefix)
				idxY_ff <= cmd.data;
			else if (cmdTake && cmd.op == OP_WR_IDX)
				idxX_ff <= cmd.data;
			else if (state_ff == S_POP_DATA && curSlot == SLOT_X)
				idxX_ff <= stkRData;
		end
	end

	// Program counter, handled as two bytes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pc_ff <= 16'h0000;
		end else if (ce) begin
			if (cmdTake && cmd.op == OP_WR_PC)
				pc_ff <= cmd.addr;
			else if (cmdTake && cmd.op == OP_WR_PCL)
				pc_ff[7:0] <= cmd.data;
			else if (cmdTake && cmd.op == OP_WR_PCH)
				pc_ff[15:8] <= cmd.data;
			else if (pushLast && seq_ff != SEQ_CC)
				pc_ff <= target_ff;
			else if (state_ff == S_POP_DATA && curSlot == SLOT_PCL)
				pc_ff[7:0] <= stkRData;
			else if (state_ff == S_POP_DATA && curSlot == SLOT_PCH)
				pc_ff[15:8] <= stkRData;
		end
	end

	// Condition flags and priority bits
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cc_ff <= CC_RESET;
		end else if (ce) begin
			if (cmdTake) begin
				unique case (cmd.op)
					OP_ALU:     cc_ff <= aluCc;
					OP_SCF:     cc_ff[CC_C] <= 1'b1;
					OP_RCF:     cc_ff[CC_C] <= 1'b0;
					OP_BIT_SET: cc_ff[cmd.bitSel] <= 1'b1;
					OP_BIT_CLR: cc_ff[cmd.bitSel] <= 1'b0;
					OP_WR_CC:   cc_ff <= cmd.data;
					OP_RIM, OP_HALT, OP_WFI: cc_ff <= setPrio(cc_ff, PRIO_LVL0);
					OP_SIM:     cc_ff <= setPrio(cc_ff, PRIO_LVL3);
					default:    cc_ff <= cc_ff;
				endcase
			end else if (pushLast && seq_ff == SEQ_INT) begin
				cc_ff <= setPrio(cc_ff, prio_ff);
			end else if (state_ff == S_POP_DATA && curSlot == SLOT_CC) begin
				cc_ff <= stkRData;
			end
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign regs = '{acc: acc_ff, idxX: idxX_ff, idxY: idxY_ff, programCounter: pc_ff,
		conditionFlags: cc_ff, stackPointer: spOut};
	assign stkPort = stk_ff;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	a_sp_reinit_value: assert property (
		(cmdTake && cmd.op == OP_RSP) |=> spOut == SP_RESET)
		else $error("stack pointer not at top after reinit");

	a_push_decrements: assert property (
		(state_ff == S_PUSH && ce) |=> spOut[6:0] == 7'($past(spOut[6:0]) - 7'h01))
		else $error("push did not decrement stack pointer");

	a_seq_stack_depth: assert property (
		(pushLast && ce) |=> spOut[6:0] == 7'(startLow_ff - {4'h0, seqLen(seq_ff)}))
		else $error("push sequence used wrong number of bytes");

	a_pcl_pushed_first: assert property (
		(cmdTake && cmd.op == OP_INT_ENTER) ##1 ce |=>
			stkPort.we && stkPort.wdata == $past(pc_ff[7:0])
			&& stkPort.addr == {SP_HIGH_FIXED, startLow_ff})
		else $error("interrupt entry did not store pc low byte first");

	a_second_idx_kept: assert property (
		(state_ff != S_IDLE) |=> $stable(idxY_ff))
		else $error("second index changed during stack sequence");

	a_half_carry_add: assert property (
		(cmdTake && cmd.op == OP_ALU && cmd.alu == ALU_ADD) |=>
			cc_ff[CC_H] == ({1'b0, $past(cmd.data[3:0])} + {1'b0, $past(cmd.opB[3:0])} > 5'h0f))
		else $error("half carry wrong after add");

	a_neg_zero_flags: assert property (
		(cmdTake && cmd.op == OP_ALU && cmd.alu != ALU_BTJ) |=>
			cc_ff[CC_N] == acc_ff[7] && cc_ff[CC_Z] == (acc_ff == 8'h00))
		else $error("negative or zero flag disagrees with result");

	a_carry_commands: assert property (
		(cmdTake && (cmd.op == OP_SCF || cmd.op == OP_RCF)) |=>
			cc_ff[CC_C] == ($past(cmd.op) == OP_SCF))
		else $error("carry not driven by set or clear command");

	a_disable_level: assert property (
		(cmdTake && cmd.op == OP_SIM) |=> {cc_ff[CC_I1], cc_ff[CC_I0]} == PRIO_LVL3)
		else $error("disable command did not select level 3");

	a_entry_priority: assert property (
		(pushLast && seq_ff == SEQ_INT && ce) |=>
			{cc_ff[CC_I1], cc_ff[CC_I0]} == $past(prio_ff) && pc_ff == $past(target_ff))
		else $error("interrupt entry priority or vector wrong");

	c_interrupt_entry: cover property (pushLast && seq_ff == SEQ_INT && ce);
	c_interrupt_return: cover property (popLast && seq_ff == SEQ_INT && ce);
	c_call_return: cover property (popLast && seq_ff == SEQ_CALL && ce);
	c_stack_wrap: cover property (state_ff == S_PUSH && ce && spOut[6:0] == 7'h00);

endmodule

// >>> shared/ccrs_pkg.sv
// Constants, types and push orders shared by the core register set
package ccrs_pkg;

	// ************************************************************
	// Reset values and field positions
	// ************************************************************
	localparam logic [7:0]  CC_RESET      = 8'he8;   // Priority level 3, flags cleared
	localparam logic [15:0] SP_RESET      = 16'h017f; // Stack top, also reinit value
	localparam logic [8:0]  SP_HIGH_FIXED = 9'h002;  // Upper sp bits held by hardware
	localparam int unsigned CC_C          = 0;       // Carry/borrow
	localparam int unsigned CC_Z          = 1;       // Zero
	localparam int unsigned CC_N          = 2;       // Negative
	localparam int unsigned CC_I0         = 3;       // priority_bit_low
	localparam int unsigned CC_H          = 4;       // Half carry
	localparam int unsigned CC_I1         = 5;       // priority_bit_high
	localparam logic [1:0]  PRIO_LVL0     = 2'h2;    // Main level, {high,low}
	localparam logic [1:0]  PRIO_LVL3     = 2'h3;    // Interrupts disabled
	localparam logic [2:0]  LEN_INT       = 3'h5;    // Interrupt context bytes
	localparam logic [2:0]  LEN_CALL      = 3'h2;    // Return address bytes
	localparam logic [2:0]  LEN_CC        = 3'h1;    // Single flag byte

	// ************************************************************
	// Enumerations and carriers
	// ************************************************************
	typedef enum logic [4:0] {
		OP_NOP, OP_WR_ACC, OP_WR_IDX, OP_WR_PC, OP_WR_PCL, OP_WR_PCH, OP_ALU,
		OP_SCF, OP_RCF, OP_BIT_SET, OP_BIT_CLR, OP_WR_CC, OP_RSP, OP_LD_SPL,
		OP_PUSH_CC, OP_POP_CC, OP_CALL, OP_RET, OP_INT_ENTER, OP_INTERRUPT_RETURN_INSTR,
		OP_RIM, OP_SIM, OP_HALT, OP_WFI
	} ccrs_op_type;

	typedef enum logic [2:0] {
		ALU_ADD, ALU_ADC, ALU_ARITH, ALU_LOGIC, ALU_SHIFT, ALU_BTJ
	} ccrs_alu_type;

	typedef enum logic [1:0] {SEQ_INT, SEQ_CALL, SEQ_CC} ccrs_seq_type;

	typedef enum logic [2:0] {SLOT_PCL, SLOT_PCH, SLOT_X, SLOT_A, SLOT_CC} ccrs_slot_type;

	typedef struct packed {
		ccrs_op_type  op;        // Command
		ccrs_alu_type alu;       // Kind of ALU result
		logic         usePrefix; // Prefix seen: second index register
		logic [7:0]   data;      // Operand A, result or written byte
		logic [7:0]   opB;       // Operand B of add
		logic         carryIn;   // Carry from shift, rotate, subtract, bit test
		logic [2:0]   bitSel;    // Flag bit for set or clear
		logic [15:0]  addr;      // Jump, call or vector address
		logic [1:0]   prio;      // source_priority_setting of the interrupt
	} ccrs_cmd_type;

	typedef struct packed {
		logic [7:0]  acc;
		logic [7:0]  idxX;
		logic [7:0]  idxY;
		logic [15:0] programCounter;
		logic [7:0]  conditionFlags;
		logic [15:0] stackPointer;
	} ccrs_view_type;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        we;
		logic        re;
	} ccrs_stk_type;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [2:0] seqLen(input ccrs_seq_type s);
		return (s == SEQ_INT) ? LEN_INT : ((s == SEQ_CALL) ? LEN_CALL : LEN_CC);
	endfunction

	// Push order; pops walk the same list backwards
	function automatic ccrs_slot_type seqSlot(input ccrs_seq_type s, input logic [2:0] idx);
		if (s == SEQ_CC)
			return SLOT_CC;
		unique case (idx)
			3'h0: return SLOT_PCL;
			3'h1: return SLOT_PCH;
			3'h2: return SLOT_X;
			3'h3: return SLOT_A;
			default: return SLOT_CC;
		endcase
	endfunction

	function automatic logic [7:0] setPrio(input logic [7:0] cc, input logic [1:0] lvl);
		logic [7:0] r;
		r = cc;
		r[CC_I1] = lvl[1];
		r[CC_I0] = lvl[0];
		return r;
	endfunction

endpackage

// >>> logic/ccrs_flag_unit.sv
// Arithmetic flag computation for the condition flags
module ccrs_flag_unit
	import ccrs_pkg::*;
(
	input  ccrs_alu_type      alu,          // Kind of result
	input  wire logic [7:0]   opA,          // Operand A or ready result
	input  wire logic [7:0]   opB,          // Operand B of add
	input  wire logic         carryIn,      // Carry supplied by sequencer
	input  wire logic [7:0]   ccIn,         // Current flags
	output logic      [7:0]   result,       // Result to accumulator
	output logic      [7:0]   ccOut,        // Updated flags
	output logic              writesResult  // Result is stored
);

	logic [8:0] sum;
	logic [4:0] nib;
	logic       cin;

	// Add, carry and result flags
	always_comb begin
		sum = 9'h000;
		nib = 5'h00;
		cin = 1'b0;
		result = opA;
		ccOut = ccIn;
		unique case (alu)
			ALU_ADD, ALU_ADC: begin
				cin = (alu == ALU_ADC) & ccIn[CC_C];
				sum = {1'b0, opA} + {1'b0, opB} + {8'h00, cin};
				nib = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, cin};
				result = sum[7:0];
				ccOut[CC_H] = nib[4];
				ccOut[CC_C] = sum[8];
			end
			ALU_ARITH, ALU_SHIFT, ALU_BTJ: ccOut[CC_C] = carryIn;
			ALU_LOGIC: ccOut[CC_C] = ccIn[CC_C];
		endcase
		if (alu != ALU_BTJ) begin
			ccOut[CC_N] = result[7];
			ccOut[CC_Z] = (result == 8'h00);
		end
	end

	assign writesResult = (alu != ALU_BTJ);

endmodule

// >>> logic/ccrs_stack_ptr.sv
// Stack pointer confined to a 128-byte wrapping stack
module ccrs_stack_ptr
	import ccrs_pkg::*;
(
	input  wire logic         clk,      // CPU clock
	input  wire logic         rstn,     // Async reset, active low
	input  wire logic         ce,       // Clock enable
	input  wire logic         reinit,   // Reinit instruction
	input  wire logic         loadLow,  // Load of low byte
	input  wire logic [7:0]   lowIn,    // Low byte to load
	input  wire logic         dec,      // After a push
	input  wire logic         inc,      // Before a pop
	output logic      [15:0]  spOut,    // Full pointer
	output logic      [15:0]  spInc     // Address of next pop
);

	logic [6:0] low_ff;

	function automatic logic [15:0] fullAddr(input logic [6:0] l);
		return {SP_HIGH_FIXED, l};
	endfunction

	// Low bits move; upper bits never stored
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			low_ff <= SP_RESET[6:0];
		end else if (ce) begin
			if (reinit)
				low_ff <= SP_RESET[6:0];
			else if (loadLow)
				low_ff <= lowIn[6:0];
			else if (dec)
				low_ff <= low_ff - 7'h01;
			else if (inc)
				low_ff <= low_ff + 7'h01;
		end
	end

	assign spOut = fullAddr(low_ff);
	assign spInc = fullAddr(low_ff + 7'h01);

	// ************************************************************
	// Checks
	// ************************************************************
	a_sp_push_wrap: assert property (@(posedge clk) disable iff (!rstn)
		(ce && dec && !reinit && !loadLow && low_ff == 7'h00) |=> low_ff == 7'h7f)
		else $error("stack pointer did not wrap to top on push");

	a_sp_pop_wrap: assert property (@(posedge clk) disable iff (!rstn)
		(ce && inc && !dec && !reinit && !loadLow && low_ff == 7'h7f) |=> low_ff == 7'h00)
		else $error("stack pointer did not wrap on pop");

endmodule

// >>> testbench/ccrs_stack_ram.sv
// Stack memory model facing the register set's stack port
module ccrs_stack_ram
	import ccrs_pkg::*;
(
	input  wire logic       clk,      // CPU clock
	input  ccrs_stk_type    stkPort,  // Stack request
	output logic      [7:0] stkRData  // Read data, one cycle latency
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:511];
	logic [7:0] rd;
	logic       vld;
	// ************************************************************
	// Synchronous stack memory
	// ************************************************************
	// Writes land at once, reads answer one cycle later
	always_ff @(posedge clk) begin
		vld <= stkPort.re;
		if (stkPort.we)
			mem[stkPort.addr[8:0]] <= stkPort.wdata;
		if (stkPort.re)
			rd <= mem[stkPort.addr[8:0]];
	end
	// Stale data shows inverted so a late sample cannot pass
	assign stkRData = vld ? rd : ~rd;
endmodule

// >>> testbench/cpu_core_register_set_bench.sv
// Self-checking bench of the core register set
module cpu_core_register_set_bench
	import ccrs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic          clk, rstn, ce, cmdValid, cmdReady;
	ccrs_cmd_type  cmd, c;
	ccrs_view_type regs;
	ccrs_stk_type  stkPort;
	logic [7:0]    stkRData, accE, ccE, xE, yE, ccS, p;
	logic [15:0]   pcE, spE;
	logic [7:0]    ctx [5];
	int            n_mismatch, tests_run, seed;
	ccrs_op_type   po [5] = '{OP_SIM, OP_RIM, OP_HALT, OP_SIM, OP_WFI};
	logic [1:0]    pl [5] = '{2'h3, 2'h2, 2'h2, 2'h3, 2'h2};

	ccrs_regset dut (.clk(clk), .rstn(rstn), .ce(ce), .cmdValid(cmdValid), .cmd(cmd),
		.cmdReady(cmdReady), .regs(regs), .stkPort(stkPort), .stkRData(stkRData));
	ccrs_stack_ram ram (.clk(clk), .stkPort(stkPort), .stkRData(stkRData));

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [7:0] rnd8();
		int v;
		v = $random(seed);
		return v[7:0];
	endfunction
	function automatic ccrs_cmd_type mk(ccrs_op_type o, logic [7:0] d, logic [15:0] a);
		ccrs_cmd_type r;
		r = '0;
		r.op = o;
		r.data = d;
		r.addr = a;
		return r;
	endfunction
	// Expected accumulator and flags after an ALU command
	function automatic logic [15:0] expAlu(ccrs_cmd_type k, logic [15:0] s);
		logic [8:0] t;
		logic [4:0] h;
		logic [7:0] r, f;
		logic       ci;
		r = k.data;
		f = s[7:0];
		ci = (k.alu == ALU_ADC) & f[0];
		if (k.alu == ALU_ADD || k.alu == ALU_ADC) begin
			t = k.data + k.opB + 9'(ci);
			h = k.data[3:0] + k.opB[3:0] + 5'(ci);
			r = t[7:0];
			f[4] = h[4];
			f[0] = t[8];
		end else if (k.alu != ALU_LOGIC)
			f[0] = k.carryIn;
		if (k.alu == ALU_BTJ)
			r = s[15:8];
		else begin
			f[2] = r[7];
			f[1] = (r == 8'h00);
		end
		return {r, f};
	endfunction
	// Cycles with cmdReady low: one per pushed byte, three per popped byte
	function automatic int expWait(ccrs_op_type o);
		case (o)
			OP_INT_ENTER: return 5;
			OP_CALL:      return 2;
			OP_PUSH_CC:   return 1;
			OP_INTERRUPT_RETURN_INSTR:      return 15;
			OP_RET:       return 6;
			OP_POP_CC:    return 3;
			default:      return 0;
		endcase
	endfunction
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chkAll();
		chk("acc", 16'(accE), 16'(regs.acc));
		chk("idxX", 16'(xE), 16'(regs.idxX));
		chk("idxY", 16'(yE), 16'(regs.idxY));
		chk("programCounter", pcE, regs.programCounter);
		chk("conditionFlags", 16'(ccE), 16'(regs.conditionFlags));
		chk("stackPointer", spE, regs.stackPointer);
	endtask
	// Offer one command, wait until the sequencer is idle again
	task automatic doCmd(input ccrs_cmd_type k);
		int n;
		n = 0;
		cmdValid = 1'b1;
		cmd = k;
		@(posedge clk);
		#1 cmdValid = 1'b0;
		while (cmdReady !== 1'b1 && n < 100) begin
			@(posedge clk);
			#1 n++;
		end
		chk("readyWait", 16'(expWait(k.op)), 16'(n));
		@(posedge clk);
		#1;
	endtask
	task automatic conclude();
		if (n_mismatch == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ************************************************************
	// Clock, watchdog and scenarios
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#100us n_mismatch++;
		conclude();
	end
	initial begin
		{rstn, cmdValid, cmd, ce} = '0;
		{n_mismatch, tests_run, seed} = {32'h0, 32'h0, 32'ha1ae};
		{accE, xE, yE, pcE, ccE, spE} = {24'h0, 16'h0, 8'he8, 16'h017f};
		repeat (3) @(posedge clk);
		#1 {rstn, ce} = 2'b11;
		chkAll();
		// Random ALU traffic with carry corners
		for (int i = 0; i < 30; i++) begin
			c = mk(OP_ALU, rnd8(), 16'h0);
			c.opB = rnd8();
			c.carryIn = rnd8() > 8'h7f;
			c.alu = ccrs_alu_type'(i % 6);
			if (i == 0)
				{c.data, c.opB} = 16'h0808;
			if (i == 6)
				{c.data, c.opB} = 16'hff01;
			{accE, ccE} = expAlu(c, {accE, ccE});
			doCmd(c);
			chkAll();
		end
		doCmd(mk(OP_SCF, 8'h0, 16'h0));
		ccE[0] = 1'b1;
		chkAll();
		doCmd(mk(OP_RCF, 8'h0, 16'h0));
		ccE[0] = 1'b0;
		chkAll();
		// Low clock enable: a command stands offered but nothing may move
		ce = 1'b0;
		cmdValid = 1'b1;
		cmd = mk(OP_WR_ACC, ~accE, 16'h0);
		repeat (3) @(posedge clk);
		#1 chkAll();
		ce = 1'b1;
		@(posedge clk);
		#1 cmdValid = 1'b0;
		accE = cmd.data;
		chkAll();
		// Single flag bits set and cleared
		for (int i = 0; i < 10; i++) begin
			c = mk((i % 2) ? OP_BIT_SET : OP_BIT_CLR, 8'h0, 16'h0);
			c.bitSel = 3'(rnd8() % 6);
			ccE[c.bitSel] = 1'(i % 2);
			doCmd(c);
			chkAll();
		end
		for (int i = 0; i < 5; i++) begin
			doCmd(mk(po[i], 8'h0, 16'h0));
			{ccE[5], ccE[3]} = pl[i];
			chkAll();
		end
		// Interrupt entry and return around both index registers
		doCmd(mk(OP_WR_PC, 8'h0, 16'h1234));
		doCmd(mk(OP_WR_PCH, 8'h56, 16'h0));
		doCmd(mk(OP_WR_PCL, 8'h9a, 16'h0));
		pcE = 16'h569a;
		doCmd(mk(OP_WR_IDX, rnd8(), 16'h0));
		xE = cmd.data;
		c = mk(OP_WR_IDX, rnd8(), 16'h0);
		c.usePrefix = 1'b1;
		yE = c.data;
		doCmd(c);
		chkAll();
		p = rnd8();
		c = mk(OP_INT_ENTER, 8'h0, 16'hab00);
		c.prio = p[1:0];
		ctx = '{pcE[7:0], pcE[15:8], xE, accE, ccE};
		ccS = ccE;
		doCmd(c);
		for (int k = 0; k < 5; k++)
			chk("stack", 16'(ctx[k]), 16'(ram.mem[spE[8:0] - 9'(k)]));
		{spE, pcE, ccE[5], ccE[3]} = {spE - 16'h5, 16'hab00, p[1:0]};
		chkAll();
		c = mk(OP_ALU, rnd8(), 16'h0);
		c.alu = ALU_LOGIC;
		{accE, ccE} = expAlu(c, {accE, ccE});
		doCmd(c);
		c = mk(OP_WR_IDX, rnd8(), 16'h0);
		c.usePrefix = 1'b1;
		yE = c.data;
		doCmd(c);
		doCmd(mk(OP_INTERRUPT_RETURN_INSTR, 8'h0, 16'h0));
		{accE, xE, pcE, ccE, spE} = {ctx[3], ctx[2], ctx[1], ctx[0], ccS, spE + 16'h5};
		chkAll();
		// Call and return, then wrap at both stack limits
		doCmd(mk(OP_CALL, 8'h0, 16'h2000));
		chk("stack", pcE, {ram.mem[spE[8:0] - 9'h1], ram.mem[spE[8:0]]});
		{spE, pcE} = {spE - 16'h2, 16'h2000};
		chkAll();
		doCmd(mk(OP_RET, 8'h0, 16'h0));
		{spE, pcE} = {spE + 16'h2, ctx[1], ctx[0]};
		chkAll();
		doCmd(mk(OP_LD_SPL, 8'h80, 16'h0));
		spE = 16'h0100;
		chkAll();
		ccS = ccE;
		doCmd(mk(OP_PUSH_CC, 8'h0, 16'h0));
		spE = 16'h017f;
		chkAll();
		doCmd(mk(OP_SIM, 8'h0, 16'h0));
		{ccE[5], ccE[3]} = 2'h3;
		doCmd(mk(OP_POP_CC, 8'h0, 16'h0));
		{spE, ccE} = {16'h0100, ccS};
		chkAll();
		p = rnd8();
		doCmd(mk(OP_LD_SPL, p, 16'h0));
		spE = {9'h002, p[6:0]};
		chkAll();
		doCmd(mk(OP_RSP, 8'h0, 16'h0));
		spE = 16'h017f;
		chkAll();
		// No-operation and direct flag write
		doCmd(mk(OP_NOP, rnd8(), 16'hffff));
		chkAll();
		p = rnd8();
		doCmd(mk(OP_WR_CC, p, 16'h0));
		ccE = p;
		chkAll();
		// Reset in mid-run brings every register back, then a call at once
		rstn = 1'b0;
		repeat (3) @(posedge clk);
		#1 rstn = 1'b1;
		{accE, xE, yE, pcE, ccE, spE} = {24'h0, 16'h0, CC_RESET, SP_RESET};
		chkAll();
		doCmd(mk(OP_CALL, 8'h0, 16'h3000));
		chk("stack", pcE, {ram.mem[spE[8:0] - 9'h1], ram.mem[spE[8:0]]});
		{spE, pcE} = {spE - 16'h2, 16'h3000};
		chkAll();
		conclude();
	end
endmodule
